// [pkg/cc_timer_pkg.sv]
// package for the two-channel capture/compare timer:
// register indexes, field positions, reset values and shared types.
// assumes a 32-bit axi4-lite master, byte address = 4 * register index.
package cc_timer_pkg;

  localparam int ADDR_W = 12;  // byte address width of the register window

  // register indexes; byte address is the index times four
  localparam logic [9:0] IDX_FREE_COUNT      = 10'h040;
  localparam logic [9:0] IDX_COUNTER_CONTROL = 10'h050;
  localparam logic [9:0] IDX_EDGE_CONTROL    = 10'h051;
  localparam logic [1:0][9:0] IDX_MATCH      = {10'h04C, 10'h04A};  // chan1, chan0
  localparam logic [1:0][9:0] IDX_LEVEL      = {10'h056, 10'h055};
  localparam logic [1:0][9:0] IDX_RELOAD     = {10'h0EC, 10'h0EA};

  // reset values
  localparam logic [15:0] WORD_RST            = 16'h0000;
  localparam logic [7:0]  COUNTER_CONTROL_RST = 8'hC0;
  localparam logic [7:0]  EDGE_CONTROL_RST    = 8'hC0;
  localparam logic [7:0]  LEVEL_CONTROL_RST   = 8'hF8;

  // writable masks and bits that always read as one
  localparam logic [7:0] COUNTER_CONTROL_WMASK = 8'h3F;
  localparam logic [7:0] EDGE_CONTROL_WMASK    = 8'h3C;
  localparam logic [7:0] UPPER_TWO_ONES        = 8'hC0;
  localparam logic [7:0] UPPER_FIVE_ONES       = 8'hF8;

  // field positions
  localparam int CLK_SEL_LSB   = 0;  // counter_control bits 2:0
  localparam int RUN_BIT       = 3;  // counter_run
  localparam int MODE_BIT0     = 4;  // chan0_mode_select, chan1 at 5
  localparam int EDGE_SEL_LSB0 = 2;  // chan0 edge select, chan1 at 4

  // capture edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // level control register, low three bits
  typedef struct packed {
    logic sub_lvl;  // level_sub_buffer_bit, bit 2
    logic buf_lvl;  // level_buffer_bit, bit 1
    logic out_lvl;  // output_level_bit, bit 0
  } chan_ctrl_t;

endpackage

// [design/cc_timer.sv]
// two-channel capture/compare timer with a shared 16-bit up-counter,
// registers reached over axi4-lite.
// assumes one clock (aclk) and a synchronous active-low reset; pins are
// split into input, output and output enable, resolved outside.
//
// What this block does
// - two channels behave identically, different addresses
// - compare mode: match value compared with counter
// - capture edge copies counter, raises channel request; here only while the counter runs
// - match values read/write, reset to zero
// - match copies level buffer bit to output
// - match copies sub-buffer bit to level buffer
// - level control: three bits, upper five read one
// - edge select bits 2-3 chan0, 4-5 chan1
// - edge control: top two read one, bottom zero
// - edge control resets to C0, no capture edge
// - pins sampled on falling clock edge
// - match loads reload buffer into match value
// - reload buffers read/write, reset to zero
// - counter takes any written value, even running
// - bits 2:0 pick clock, bit 3 runs counter
// - bits 4/5 pick channel mode, one captures
// - output level bit written sets initial pin level
// - counter wraps to zero, raises overflow request
// - counter control resets C0, top bits read one
// - compare match raises the shared channel request
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
module cc_timer
  import cc_timer_pkg::*;
#(
  // log2 of the divide ratio for each clock select code, code 0 lowest
  parameter logic [23:0] DIV_LOG2_TBL = {3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0}
)
(
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [cc_timer_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  input  wire logic [cc_timer_pkg::ADDR_W-1:0] araddr,
  input  wire logic                           arvalid,
  output logic                                arready,
  output logic [31:0]                         rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  input  wire logic [1:0]                     chan_pin_in,
  output logic [1:0]                          chan_pin_out,
  output logic [1:0]                          chan_pin_oe,
  output logic                                overflow_irq,
  output logic [1:0]                          chan_irq
);

  import cc_timer_pkg::*;

  // bus handshake state
  logic        awready_r;      // write address and data taken together
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  // timer state
  logic [15:0] count_r;             // free_running_count
  logic [7:0]  counter_control_r;   // upper two bits held at one
  logic [7:0]  edge_control_r;      // capture_edge_control
  logic [6:0]  prescale_r;          // free divider for the count clock
  logic        overflow_irq_r;

  // per-channel views gathered from the generate loop
  logic [15:0] match_w  [2];
  logic [15:0] reload_w [2];
  chan_ctrl_t  level_w  [2];
  logic [1:0]  pin_out_w;
  logic [1:0]  pin_oe_w;
  logic [1:0]  irq_w;

  // decoded strobes
  logic        wr_fire;        // write handshake edge
  logic        rd_fire;        // read handshake edge
  logic [9:0]  wr_idx;
  logic [9:0]  rd_idx;
  logic        wr_count;
  logic        wr_counter_control;
  logic        wr_edge_control;
  logic        run;
  logic [2:0]  div_log2;
  logic [6:0]  div_mask;
  logic        count_tick;     // counter advances this edge
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;

  // merge a 16-bit register with the two low byte lanes of a write
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  // address decode; an access is taken one edge after both valids show
  assign wr_fire = awready_r && awvalid && wvalid;
  assign rd_fire = arready_r && arvalid;
  assign wr_idx  = awaddr[ADDR_W-1:2];
  assign rd_idx  = araddr[ADDR_W-1:2];

  assign wr_count           = wr_fire && (wr_idx == IDX_FREE_COUNT);
  assign wr_counter_control = wr_fire && (wr_idx == IDX_COUNTER_CONTROL) && wstrb[0];
  assign wr_edge_control    = wr_fire && (wr_idx == IDX_EDGE_CONTROL) && wstrb[0];

  // any printed register index answers okay, everything else decerr
  assign wr_hit = (wr_idx == IDX_FREE_COUNT) || (wr_idx == IDX_COUNTER_CONTROL) ||
                  (wr_idx == IDX_EDGE_CONTROL) ||
                  (wr_idx == IDX_MATCH[0]) || (wr_idx == IDX_MATCH[1]) ||
                  (wr_idx == IDX_LEVEL[0]) || (wr_idx == IDX_LEVEL[1]) ||
                  (wr_idx == IDX_RELOAD[0]) || (wr_idx == IDX_RELOAD[1]);

  // clock select through the divider table and run gating
  assign run        = counter_control_r[RUN_BIT];
  assign div_log2   = DIV_LOG2_TBL[3*counter_control_r[CLK_SEL_LSB +: 3] +: 3];
  assign div_mask   = 7'((8'd1 << div_log2) - 8'd1);
  assign count_tick = run && ((prescale_r & div_mask) == div_mask);

  // write channel: raise both readies for one cycle, then answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b1;
      bresp_r   <= wr_hit ? RESP_OKAY : RESP_DECERR;
    end
    else
    begin
      // only one write in flight: wait until the response is gone
      awready_r <= awvalid && wvalid && !bvalid_r && !awready_r;
      wready_r  <= awvalid && wvalid && !bvalid_r && !awready_r;
      if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  // read mux; fixed bits merged in here, though both control registers also store their upper ones
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (rd_idx == IDX_FREE_COUNT)
      rd_word[15:0] = count_r;
    else if (rd_idx == IDX_COUNTER_CONTROL)
      rd_word[7:0] = counter_control_r | UPPER_TWO_ONES;
    else if (rd_idx == IDX_EDGE_CONTROL)
      rd_word[7:0] = (edge_control_r & EDGE_CONTROL_WMASK) | UPPER_TWO_ONES;
    else if (rd_idx == IDX_MATCH[0])
      rd_word[15:0] = match_w[0];
    else if (rd_idx == IDX_MATCH[1])
      rd_word[15:0] = match_w[1];
    else if (rd_idx == IDX_LEVEL[0])
      rd_word[7:0] = UPPER_FIVE_ONES | {5'h00, level_w[0]};
    else if (rd_idx == IDX_LEVEL[1])
      rd_word[7:0] = UPPER_FIVE_ONES | {5'h00, level_w[1]};
    else if (rd_idx == IDX_RELOAD[0])
      rd_word[15:0] = reload_w[0];
    else if (rd_idx == IDX_RELOAD[1])
      rd_word[15:0] = reload_w[1];
    else
      rd_hit = 1'b0;
  end

  // read channel: arready for one cycle, data registered on the handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      rdata_r   <= rd_word;
    end
    else
    begin
      arready_r <= arvalid && !rvalid_r && !arready_r;
      if (rvalid_r && rready)
        rvalid_r <= 1'b0;
    end
  end

  // free-running prescaler; never reset by software so ratios stay exact
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prescale_r <= 7'h00;
    else
      prescale_r <= prescale_r + 7'd1;
  end

  // counter control and capture edge control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      counter_control_r <= COUNTER_CONTROL_RST;
      edge_control_r    <= EDGE_CONTROL_RST;
    end
    else
    begin
      if (wr_counter_control)  // upper two bits stay one
        counter_control_r <= (wdata[7:0] & COUNTER_CONTROL_WMASK) | UPPER_TWO_ONES;
      if (wr_edge_control)     // low bit pair stored as zero, upper pair as one
        edge_control_r <= (wdata[7:0] & EDGE_CONTROL_WMASK) | UPPER_TWO_ONES;
    end
  end

  // counter: a write wins over the tick so software sets the start value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_r        <= WORD_RST;
      overflow_irq_r <= 1'b0;
    end
    else
    begin
      overflow_irq_r <= count_tick && !wr_count && (count_r == 16'hFFFF);
      if (wr_count)
        count_r <= merge16(count_r, wdata, wstrb);
      else if (count_tick)
        count_r <= count_r + 16'd1;  // wraps to zero
    end
  end

  // two identical channels; only their register indexes, mode and edge select bits and pins differ
  for (genvar g = 0; g < 2; g++)
  begin : chan
    logic       pin_fall_r;   // falling-edge sample of the pin
    logic       pin_q_r;      // second stage, sole reader of pin_fall_r
    logic       pin_prev_r;   // previous sample for edge detection
    logic [15:0] match_r;
    logic [15:0] reload_r;
    chan_ctrl_t  level_r;
    logic       oe_r;
    logic       irq_r;
    logic       capture_mode;
    logic [1:0] edge_sel;
    logic       edge_seen;
    logic       cap_hit;
    logic       cmp_hit;
    logic       wr_match;
    logic       wr_reload;
    logic       wr_level;

    assign capture_mode = counter_control_r[MODE_BIT0 + g];
    assign edge_sel     = edge_control_r[EDGE_SEL_LSB0 + 2*g +: 2];
    assign wr_match     = wr_fire && (wr_idx == IDX_MATCH[g]);
    assign wr_reload    = wr_fire && (wr_idx == IDX_RELOAD[g]);
    assign wr_level     = wr_fire && (wr_idx == IDX_LEVEL[g]) && wstrb[0];

    // edge decode; code zero disables capture
    always_comb
    begin
      unique case (edge_sel)
        EDGE_RISE: edge_seen = pin_q_r && !pin_prev_r;
        EDGE_FALL: edge_seen = !pin_q_r && pin_prev_r;
        EDGE_BOTH: edge_seen = pin_q_r ^ pin_prev_r;
        EDGE_NONE: edge_seen = 1'b0;
      endcase
    end

    // capture only while the counter runs; compare only on a count tick
    assign cap_hit = run && capture_mode && edge_seen;
    assign cmp_hit = count_tick && !capture_mode && (count_r == match_r);

    // pin sampled on the falling edge; pulses must outlast one clock
    always_ff @(negedge aclk)
    begin
      if (!aresetn)
        pin_fall_r <= 1'b0;
      else
        pin_fall_r <= chan_pin_in[g];
    end

    // bring the sample into the rising-edge domain
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pin_q_r    <= 1'b0;
        pin_prev_r <= 1'b0;
      end
      else
      begin
        pin_q_r    <= pin_fall_r;
        pin_prev_r <= pin_q_r;
      end
    end

    // match value: hardware events win over a write in the same cycle
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        match_r <= WORD_RST;
      else if (cap_hit)
        match_r <= count_r;
      else if (cmp_hit)
        match_r <= reload_r;
      else if (wr_match)
        match_r <= merge16(match_r, wdata, wstrb);
    end

    // reload buffer, software only
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        reload_r <= WORD_RST;
      else if (wr_reload)
        reload_r <= merge16(reload_r, wdata, wstrb);
    end

    // level queue; a write landing on a match keeps only its sub bit,
    // which is why a read-modify-write near a match can misbehave
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        level_r <= chan_ctrl_t'(LEVEL_CONTROL_RST[2:0]);
      else if (cmp_hit)
      begin
        level_r.out_lvl <= level_r.buf_lvl;
        level_r.buf_lvl <= level_r.sub_lvl;
        if (wr_level)
          level_r.sub_lvl <= wdata[2];
      end
      else if (wr_level)
        level_r <= chan_ctrl_t'(wdata[2:0]);  // initial pin level
    end

    // pin enable follows the mode; request pulse covers both causes
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        oe_r  <= 1'b0;
        irq_r <= 1'b0;
      end
      else
      begin
        oe_r  <= !capture_mode;
        irq_r <= cap_hit || cmp_hit;
      end
    end

    assign match_w[g]   = match_r;
    assign reload_w[g]  = reload_r;
    assign level_w[g]   = level_r;
    assign pin_out_w[g] = level_r.out_lvl;
    assign pin_oe_w[g]  = oe_r;
    assign irq_w[g]     = irq_r;
  end

  // outputs, each straight from a flip-flop
  assign awready      = awready_r;
  assign wready       = wready_r;
  assign bvalid       = bvalid_r;
  assign bresp        = bresp_r;
  assign arready      = arready_r;
  assign rvalid       = rvalid_r;
  assign rresp        = rresp_r;
  assign rdata        = rdata_r;
  assign chan_pin_out = pin_out_w;
  assign chan_pin_oe  = pin_oe_w;
  assign chan_irq     = irq_w;
  assign overflow_irq = overflow_irq_r;

endmodule // cc_timer

// [tb/cc_timer_monitor.sv]
// port checker for the capture/compare timer
// assumes rising-edge aclk and a synchronous active-low aresetn
module cc_timer_monitor
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  chan_pin_out,
  input wire logic [1:0]  chan_irq,
  input wire logic        overflow_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a full write offer is taken one cycle later
  a_wr_take: assert property (awvalid && wvalid && !awready && !bvalid |=>
    awready && wready)
    else $error("write offer not taken");
  a_wr_resp: assert property (awvalid && awready |=> bvalid)
    else $error("write response missing");
  // no new write while a response waits
  a_b_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rd_take: assert property (arvalid && !arready && !rvalid |=> arready)
    else $error("read offer not taken");
  a_rd_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  // wrap request is a single-cycle pulse
  a_ovf_pulse: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow request too long");
  // a pin moves only on a register write or on a match; the match request
  // comes from the same edge as the new level, so both show in one cycle
  a_out_cause: assert property ($changed(chan_pin_out) |->
    $past(awready) || (chan_irq != 2'h0))
    else $error("pin changed without cause");
endmodule // cc_timer_monitor

bind cc_timer cc_timer_monitor i_mon (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .chan_pin_out,
  .chan_irq, .overflow_irq);

// [tb/cc_pin_driver.sv]
// model of the external pulse sources on the two capture pins
// assumes the bench raises fire for one aclk cycle per wanted pulse
module cc_pin_driver
#(
  parameter int WIDTH = 4  // pulse length in aclk cycles
)
(
  input  wire logic       aclk,
  input  wire logic [1:0] fire,
  output logic [1:0]      pin
);
  timeunit 1ns;
  timeprecision 1ps;

  int left [2] = '{0, 0};  // cycles left in each pulse

  // idle low as if pulled down; pulses last over one clock so the
  // falling-edge sampler cannot miss them
  initial pin = 2'h0;
  always @(posedge aclk)
  begin
    for (int g = 0; g < 2; g++)
    begin
      if (fire[g])
        left[g] = WIDTH;
      else if (left[g] > 0)
        left[g] = left[g] - 1;
      pin[g] <= (left[g] > 0);
    end
  end
endmodule // cc_pin_driver

// [tb/tb.sv]
// self-checking bench for the two-channel capture/compare timer
// assumes package, timer, checker and pin model compiled before it
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cc_timer_pkg::*;

  // byte addresses, four times the register index
  localparam logic [11:0] CNT = 12'h100, CC = 12'h140, EDG = 12'h144;
  logic [11:0] ma [2] = '{12'h128, 12'h130};  // match values
  logic [11:0] la [2] = '{12'h154, 12'h158};  // level controls
  logic [11:0] ba [2] = '{12'h3a8, 12'h3b0};  // reload buffers
  logic [11:0] ra [9] = '{CNT, CC, EDG, 12'h128, 12'h130, 12'h154, 12'h158,
                          12'h3a8, 12'h3b0};
  logic [7:0]  rv [9] = '{8'h0, 8'hc0, 8'hc0, 8'h0, 8'h0, 8'hf8, 8'hf8, 8'h0, 8'h0};
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic        bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v, r;
  logic [3:0]  wstrb = 4'hf;  // all lanes on: each register keeps its own
  logic [1:0]  fire = 2'h0, chan_pin_in, bresp, rresp, chan_pin_out, chan_pin_oe, chan_irq;
  logic        awready, wready, bvalid, arready, rvalid, overflow_irq;
  logic [34:0] q [$], e;  // noted reads: skip flag, response, data
  logic [1:0]  qb [$];    // noted write responses
  int          fails = 0, n_checks = 0, cyc = 0, novf = 0, d, nirq [2];
  int          seed = 32'h0000_f36d;

  always #4 aclk = ~aclk;

  cc_timer i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .chan_pin_in, .chan_pin_out, .chan_pin_oe, .overflow_irq, .chan_irq);
  cc_pin_driver i_pins (.aclk, .fire, .pin(chan_pin_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one write; bready comes a cycle late so the response must wait
  task automatic wr(input logic [11:0] a, input logic [31:0] w, input logic [1:0] er = RESP_OKAY);
    qb.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= w;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do @(posedge aclk); while (awready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h1;
    @(posedge aclk);
    bready <= 1'h0;
  endtask

  // one read; the expectation is noted first, f[2] leaves data to the caller
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [2:0] f = 3'h0);
    q.push_back({f, x});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge aclk);
    v = rdata;
    rready <= 1'h0;
  endtask

  task automatic wait_irq(input int g);
    do @(posedge aclk); while (chan_irq[g] !== 1'h1);
  endtask

  // compares every bus answer with the oldest note of its kind
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      e = q.pop_front();
      chk(32'(rresp), 32'(e[33:32]));
      if (!e[34])
        chk(rdata, e[31:0]);
    end
    if (bvalid && bready)
      chk(32'(bresp), 32'(qb.pop_front()));
  end

  // request counters and the hang limit
  always @(posedge aclk)
  begin
    cyc++;
    nirq[0] += chan_irq[0];
    nirq[1] += chan_irq[1];
    novf += overflow_irq;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values, then a hole in the map
    foreach (ra[i]) rd(ra[i], 32'(rv[i]));
    rd(12'h004, '0, 3'h3);
    chk(32'(chan_pin_oe), 32'h3);
    // fixed bits ignore writes; word registers keep random values
    wr(EDG, 32'hffff_ffff);
    rd(EDG, 32'hfc);
    wr(12'h008, 32'h1, RESP_DECERR);
    for (int g = 0; g < 2; g++)
    begin
      wr(la[g], 32'hffff_ffff);
      chk(32'(chan_pin_out[g]), 32'h1);
      rd(la[g], 32'hff);
      r = $random(seed);
      wr(ma[g], r);
      rd(ma[g], r & 32'hffff);
      wr(ba[g], ~r);
      rd(ba[g], ~r & 32'hffff);
    end
    wr(CNT, r);
    rd(CNT, r & 32'hffff);
    // two matches per channel, the second from the reload buffer
    for (int g = 0; g < 2; g++)
    begin
      wr(la[g], 32'h5);  // set while halted, far from any match
      wr(ma[g], 32'(64 + 16 * g));
      wr(ba[g], 32'(128 + 16 * g));
    end
    wr(CNT, 32'h10);
    wr(CC, 32'h8);
    for (int k = 0; k < 2; k++)
      for (int g = 0; g < 2; g++)
      begin
        wait_irq(g);
        chk(32'(chan_pin_out[g]), 32'(k));
      end
    wr(CC, 32'h0);
    for (int g = 0; g < 2; g++)
    begin
      rd(ma[g], 32'(128 + 16 * g));
      rd(la[g], 32'hff);
    end
    // a halted counter neither moves nor matches
    wr(CNT, 32'h80);
    nirq = '{0, 0};
    repeat (8) @(posedge aclk);
    chk(32'(nirq[0] + nirq[1]), 32'h0);
    rd(CNT, 32'h80);
    // wrap, then each clock select code over 261 ticks of aclk
    wr(CNT, 32'hfff8);
    novf = 0;
    wr(CC, 32'h8);
    repeat (12) @(posedge aclk);
    chk(32'(novf), 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      wr(CC, 32'h0);
      wr(CNT, 32'h0);
      wr(CC, 32'(8 + c));
      repeat (256) @(posedge aclk);
      wr(CC, 32'h0);
      rd(CNT, '0, 3'h4);
      d = int'(v[15:0]) - (261 >> c);
      chk(32'(d >= -2 && d <= 2), 32'h1);
    end
    // both channels under every edge code; code zero captures nothing
    wr(CC, 32'h38);
    chk(32'(chan_pin_oe), 32'h0);
    wr(CNT, 32'h1000);
    for (int k = 0; k < 4; k++)
    begin
      wr(EDG, 32'(20 * k));
      nirq = '{0, 0};
      fire <= 2'h3;
      @(posedge aclk);
      fire <= 2'h0;
      repeat (20) @(posedge aclk);
      for (int g = 0; g < 2; g++)
        chk(32'(nirq[g]), 32'((k + 1) / 2));
    end
    rd(ma[1], '0, 3'h4);
    chk(32'(v[15:12]), 32'h1);
    // second reset in mid-run
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ma[1], '0);
    rd(CC, 32'hc0);
    close_out();
  end
endmodule // tb
